// >>> rftmr_pkg.sv
// constants, field layout and carriers of the first reader timer unit
// assumes a 25 MHz system clock and a word-indexed Avalon-MM slave port
package rftmr_pkg;

    localparam int unsigned CLK_HZ  = 25_000_000;
    localparam int unsigned FAST_HZ = 13_560_000;
    localparam int unsigned SLOW_HZ = 211_875;
    localparam int unsigned ACC_W   = 24;
    localparam logic [ACC_W-1:0] FAST_INC =
        ACC_W'((64'(FAST_HZ) << ACC_W) / 64'(CLK_HZ));
    localparam logic [ACC_W-1:0] SLOW_INC =
        ACC_W'((64'(SLOW_HZ) << ACC_W) / 64'(CLK_HZ));

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_RUN_CTL  = 6'h0E;
    localparam logic [5:0] IDX_CONFIG   = 6'h0F;
    localparam logic [5:0] IDX_RELOAD_H = 6'h10;
    localparam logic [5:0] IDX_RELOAD_L = 6'h11;
    localparam logic [5:0] IDX_COUNT_H  = 6'h12;
    localparam logic [5:0] IDX_COUNT_L  = 6'h13;
    localparam logic [5:0] IDX_FLAGS    = 6'h3F;

    // run control layout
    localparam int unsigned RUN_LSB  = 4;
    localparam int unsigned MASK_LSB = 0;

    // config and flags layout
    localparam int unsigned CFG_HALT  = 7;
    localparam int unsigned CFG_START = 4;
    localparam int unsigned CFG_AUTO  = 3;
    localparam int unsigned CFG_CLK   = 0;
    localparam int unsigned FLAG_UF   = 0;

    localparam logic [1:0] START_SW     = 2'h0;
    localparam logic [1:0] START_TX     = 2'h1;
    localparam logic [1:0] START_TRIM   = 2'h2;
    localparam logic [1:0] START_TRIMUF = 2'h3;

    localparam logic [1:0] CLK_FAST = 2'h0;
    localparam logic [1:0] CLK_SLOW = 2'h1;
    localparam logic [1:0] CLK_TWO  = 2'h2;
    localparam logic [1:0] CLK_ONE  = 2'h3;

    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_COUNT = 16'h0000;

    typedef struct packed {
        logic       halt_on_receive;
        logic [1:0] start_mode_sel;
        logic       auto_reload_enable;
        logic [1:0] count_clock_sel;
    } rftmr_cfg_t;

    typedef struct packed {
        logic tx_done;
        logic rx_first_bits;
        logic timer_one_underflow;
        logic timer_two_underflow;
    } rftmr_evt_t;

endpackage

// >>> rftmr_timer0.sv
// timer run control register and the complete timer zero down-counter
// assumes same-clock event pulses, a raw slow oscillator pin, Avalon-MM master
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ns
module rftmr_timer0 (
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_i,
    input  wire logic [5:0]           avs_address_i,
    input  wire logic                 avs_read_i,
    input  wire logic                 avs_write_i,
    input  wire logic [31:0]          avs_writedata_i,
    input  wire logic [3:0]           avs_byteenable_i,
    output logic      [31:0]          avs_readdata_o,
    output logic                      avs_waitrequest_o,
    input  wire rftmr_pkg::rftmr_evt_t evt_i,
    input  wire logic                 slow_oscillator_i,
    input  wire logic [2:0]           others_active_i,
    output logic      [2:0]           others_start_o,
    output logic      [2:0]           others_stop_o,
    output logic                      timer_zero_active_o,
    output logic                      timer_zero_underflow_o,
    output logic                      underflow_irq_flag_o
);
    import rftmr_pkg::*;

    logic              ack_q;
    logic [31:0]       rdata_q;
    logic              wr_acc;
    logic              wr_run;
    logic              wr_cfg;
    logic              wr_rl_h;
    logic              wr_rl_l;
    logic              wr_flags;
    logic [7:0]        wbyte;
    logic [7:0]        rbyte;
    rftmr_cfg_t        cfg_q;
    logic [7:0]        reload_word_high_q;
    logic [7:0]        reload_word_low_q;
    logic [15:0]       reload_word;
    logic [15:0]       count_q;
    logic              active_q;
    logic              flag_q;
    logic              uf_q;
    logic [2:0]        ostart_q;
    logic [2:0]        ostop_q;
    logic [ACC_W-1:0]  fast_acc_q;
    logic [ACC_W-1:0]  slow_acc_q;
    logic [ACC_W:0]    fast_sum;
    logic [ACC_W:0]    slow_sum;
    logic              fast_tick;
    logic              slow_tick;
    logic              tick;
    logic              osc_meta_q;
    logic              osc_sync_q;
    logic              osc_prev_q;
    logic              osc_rise;
    logic              trim_mode;
    logic              sw_start;
    logic              sw_stop;
    logic              tx_start;
    logic              trim_start;
    logic              trim_stop;
    logic              rx_halt;
    logic              at_zero;
    logic              underflow;
    logic              uf_stop;
    logic              start_evt;

    // register index match
    function automatic logic hit(input logic [5:0] addr, input logic [5:0] idx);
        hit = (addr == idx);
    endfunction

    // one step of a phase accumulator, carry marks a tick
    function automatic logic [ACC_W:0] nco_step(input logic [ACC_W-1:0] acc,
                                                 input logic [ACC_W-1:0] inc);
        nco_step = {1'b0, acc} + {1'b0, inc};
    endfunction

    // bus slave: one wait state, then answer
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
    assign avs_readdata_o    = rdata_q;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
        end
    end

    assign wr_acc   = avs_write_i & ack_q & avs_byteenable_i[0];
    assign wbyte    = avs_writedata_i[7:0];
    assign wr_run   = wr_acc & hit(avs_address_i, IDX_RUN_CTL);
    assign wr_cfg   = wr_acc & hit(avs_address_i, IDX_CONFIG);
    assign wr_rl_h  = wr_acc & hit(avs_address_i, IDX_RELOAD_H);
    assign wr_rl_l  = wr_acc & hit(avs_address_i, IDX_RELOAD_L);
    assign wr_flags = wr_acc & hit(avs_address_i, IDX_FLAGS);

    // read mux, unmapped reads give zero
    always_comb begin
        rbyte = RST_BYTE;
        if (hit(avs_address_i, IDX_RUN_CTL)) begin
            rbyte = {others_active_i, active_q, 4'h0};
        end else if (hit(avs_address_i, IDX_CONFIG)) begin
            rbyte = {cfg_q.halt_on_receive, 1'b0, cfg_q.start_mode_sel,
                     cfg_q.auto_reload_enable, 1'b0, cfg_q.count_clock_sel};
        end else if (hit(avs_address_i, IDX_RELOAD_H)) begin
            rbyte = reload_word_high_q;
        end else if (hit(avs_address_i, IDX_RELOAD_L)) begin
            rbyte = reload_word_low_q;
        end else if (hit(avs_address_i, IDX_COUNT_H)) begin
            rbyte = count_q[15:8];
        end else if (hit(avs_address_i, IDX_COUNT_L)) begin
            rbyte = count_q[7:0];
        end else if (hit(avs_address_i, IDX_FLAGS)) begin
            rbyte = {7'h00, flag_q};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h00000000;
        end else if (avs_read_i & ~ack_q) begin
            rdata_q <= {24'h000000, rbyte};
        end
    end

    // configuration register, reserved bits dropped
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cfg_q <= rftmr_cfg_t'(6'h00);
        end else if (wr_cfg) begin
            cfg_q.halt_on_receive    <= wbyte[CFG_HALT];
            cfg_q.start_mode_sel     <= wbyte[CFG_START +: 2];
            cfg_q.auto_reload_enable <= wbyte[CFG_AUTO];
            cfg_q.count_clock_sel    <= wbyte[CFG_CLK +: 2];
        end
    end

    // reload bytes, used at a start event and at an auto-reload underflow
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            reload_word_high_q <= RST_BYTE;
            reload_word_low_q  <= RST_BYTE;
        end else begin
            if (wr_rl_h) begin
                reload_word_high_q <= wbyte;
            end
            if (wr_rl_l) begin
                reload_word_low_q <= wbyte;
            end
        end
    end

    assign reload_word = {reload_word_high_q, reload_word_low_q};

    // count clock generators
    assign fast_sum = nco_step(fast_acc_q, FAST_INC);
    assign slow_sum = nco_step(slow_acc_q, SLOW_INC);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            fast_acc_q <= '0;
            slow_acc_q <= '0;
        end else begin
            fast_acc_q <= fast_sum[ACC_W-1:0];
            slow_acc_q <= slow_sum[ACC_W-1:0];
        end
    end

    assign fast_tick = fast_sum[ACC_W];
    assign slow_tick = slow_sum[ACC_W];

    always_comb begin
        tick = 1'b0;
        case (cfg_q.count_clock_sel)
            CLK_FAST: tick = fast_tick;
            CLK_SLOW: tick = slow_tick;
            CLK_TWO:  tick = evt_i.timer_two_underflow;
            CLK_ONE:  tick = evt_i.timer_one_underflow;
            default:  tick = 1'b0;
        endcase
    end

    // slow oscillator pin synchroniser and edge
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            osc_meta_q <= 1'b0;
            osc_sync_q <= 1'b0;
            osc_prev_q <= 1'b0;
        end else begin
            osc_meta_q <= slow_oscillator_i;
            osc_sync_q <= osc_meta_q;
            osc_prev_q <= osc_sync_q;
        end
    end

    assign osc_rise = osc_sync_q & ~osc_prev_q;

    // start and stop causes
    assign trim_mode  = cfg_q.start_mode_sel[1];
    assign sw_start   = wr_run & wbyte[MASK_LSB] & wbyte[RUN_LSB];
    assign sw_stop    = wr_run & wbyte[MASK_LSB] & ~wbyte[RUN_LSB];
    assign tx_start   = ~active_q & (cfg_q.start_mode_sel == START_TX)
                        & evt_i.tx_done;
    assign trim_start = trim_mode & osc_rise & ~active_q;
    assign trim_stop  = trim_mode & osc_rise & active_q;
    assign rx_halt    = active_q & cfg_q.halt_on_receive & ~trim_mode
                        & evt_i.rx_first_bits;
    assign at_zero    = (count_q == RST_COUNT);
    assign underflow  = active_q & tick & at_zero
                        & (cfg_q.start_mode_sel != START_TRIM);
    assign uf_stop    = underflow & ~cfg_q.auto_reload_enable;
    assign start_evt  = sw_start | tx_start | trim_start;

    // running status
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            active_q <= 1'b0;
        end else if (sw_start) begin
            active_q <= 1'b1;
        end else if (sw_stop) begin
            active_q <= 1'b0;
        end else if (tx_start | trim_start) begin
            active_q <= 1'b1;
        end else if (rx_halt | trim_stop | uf_stop) begin
            active_q <= 1'b0;
        end
    end

    // down-counter
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            count_q <= RST_COUNT;
        end else if (start_evt) begin
            count_q <= reload_word;
        end else if (active_q & tick & ~sw_stop) begin
            if (!at_zero) begin
                count_q <= count_q - 16'h0001;
            end else if (underflow & cfg_q.auto_reload_enable) begin
                count_q <= reload_word;
            end
        end
    end

    // underflow flag, set wins over clear
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            flag_q <= 1'b0;
        end else if (underflow) begin
            flag_q <= 1'b1;
        end else if (wr_flags & wbyte[FLAG_UF]) begin
            flag_q <= 1'b0;
        end
    end

    // underflow pulse for cascading
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            uf_q <= 1'b0;
        end else begin
            uf_q <= underflow;
        end
    end

    // masked start and stop requests to the other timers
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ostart_q <= 3'h0;
            ostop_q  <= 3'h0;
        end else if (wr_run) begin
            ostart_q <= wbyte[MASK_LSB+1 +: 3] & wbyte[RUN_LSB+1 +: 3];
            ostop_q  <= wbyte[MASK_LSB+1 +: 3] & ~wbyte[RUN_LSB+1 +: 3];
        end else begin
            ostart_q <= 3'h0;
            ostop_q  <= 3'h0;
        end
    end

    assign others_start_o         = ostart_q;
    assign others_stop_o          = ostop_q;
    assign timer_zero_active_o    = active_q;
    assign timer_zero_underflow_o = uf_q;
    assign underflow_irq_flag_o   = flag_q;

endmodule

// >>> rftmr_timer0_sva.sv
// port assertions for the timer zero unit
// assumes one Avalon-MM request at a time, bound to rftmr_timer0
`timescale 1ns/1ns
module rftmr_timer0_sva (
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic [5:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic [2:0]  others_active_i,
    input wire logic [2:0]  others_start_o,
    input wire logic [2:0]  others_stop_o,
    input wire logic        timer_zero_active_o,
    input wire logic        timer_zero_underflow_o,
    input wire logic        underflow_irq_flag_o
);
    import rftmr_pkg::*;
    logic       wr_ctl;
    logic       rd_ok;
    logic [7:0] wd;
    assign wd     = avs_writedata_i[7:0];
    assign rd_ok  = avs_read_i && !avs_waitrequest_o;
    assign wr_ctl = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
                    && avs_address_i == IDX_RUN_CTL;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    property p_start; wr_ctl && wd[4] && wd[0] |=> timer_zero_active_o; endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_stop; wr_ctl && !wd[4] && wd[0] |=> !timer_zero_active_o; endproperty
    a_stop: assert property (p_stop) else $error("no stop");
    property p_oth; wr_ctl && wd[5] && wd[1] |=> others_start_o[0] && !others_stop_o[0];
    endproperty
    a_oth: assert property (p_oth) else $error("no start pulse");
    property p_nomask; wr_ctl && wd[3:1] == 3'h0 |=> (others_start_o | others_stop_o) == 3'h0;
    endproperty
    a_nomask: assert property (p_nomask) else $error("unmasked change");
    property p_rdrun; rd_ok && avs_address_i == IDX_RUN_CTL |-> avs_readdata_o[7:0] ==
        {$past(others_active_i), $past(timer_zero_active_o), 4'h0}; endproperty
    a_rdrun: assert property (p_rdrun) else $error("bad run readback");
    property p_rsv; rd_ok && avs_address_i == IDX_CONFIG |-> !avs_readdata_o[6] &&
        !avs_readdata_o[2]; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit set");
    property p_flag; timer_zero_underflow_o |-> underflow_irq_flag_o; endproperty
    a_flag: assert property (p_flag) else $error("flag missing");
    property p_cause; $rose(underflow_irq_flag_o) |-> timer_zero_underflow_o; endproperty
    a_cause: assert property (p_cause) else $error("flag without underflow");
endmodule

bind rftmr_timer0 rftmr_timer0_sva u_sva (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .others_active_i(others_active_i), .others_start_o(others_start_o),
    .others_stop_o(others_stop_o), .timer_zero_active_o(timer_zero_active_o),
    .timer_zero_underflow_o(timer_zero_underflow_o),
    .underflow_irq_flag_o(underflow_irq_flag_o));

// >>> rftmr_timer0_test.sv
// register-level bench for the timer zero unit
// assumes the one-wait-state Avalon-MM slave of rftmr_timer0
`timescale 1ns/1ns
module rftmr_timer0_test;
    import rftmr_pkg::*;
    logic        ref_clk_i, rst_i, rd_i, wr_i, osc_i, act_o, uf_o, flag_o, wait_o;
    logic [5:0]  addr_i;
    logic [31:0] wdata_i, rdata_o;
    logic [2:0]  oth_i, ost_o, osp_o;
    logic [7:0]  rd;
    rftmr_evt_t  evt_i, e1, e2;
    int          num_errors = 0, checks_done = 0, uf_n = 0, n, base;

    rftmr_timer0 DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address_i(addr_i),
        .avs_read_i(rd_i), .avs_write_i(wr_i), .avs_writedata_i(wdata_i),
        .avs_byteenable_i(4'hF), .avs_readdata_o(rdata_o), .avs_waitrequest_o(wait_o),
        .evt_i(evt_i), .slow_oscillator_i(osc_i), .others_active_i(oth_i),
        .others_start_o(ost_o), .others_stop_o(osp_o), .timer_zero_active_o(act_o),
        .timer_zero_underflow_o(uf_o), .underflow_irq_flag_o(flag_o));

    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i) begin
        if (uf_o === 1'b1) uf_n <= uf_n + 1;
    end

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic acc(input logic we, input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i  <= a;
        wdata_i <= {24'h000000, d};
        wr_i    <= we;
        rd_i    <= ~we;
        do begin
            @(posedge ref_clk_i);
        end while (wait_o !== 1'b0);
        rd = rdata_o[7:0];
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(negedge ref_clk_i);
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
    endtask

    task automatic rdc(input string nm, input logic [5:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        chk(nm, rd, exp);
    endtask

    task automatic ev(input rftmr_evt_t e, input int cnt);
        repeat (cnt) begin
            @(posedge ref_clk_i);
            evt_i <= e;
            @(posedge ref_clk_i);
            evt_i <= '0;
        end
        repeat (2) @(negedge ref_clk_i);
    endtask

    task automatic print_verdict;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        num_errors++;
        print_verdict();
    end

    initial begin
        {rst_i, rd_i, wr_i, osc_i, addr_i, wdata_i, evt_i} = '0;
        rst_i = 1'b1;
        oth_i = 3'b101;
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rdc("run_ctl", IDX_RUN_CTL, 8'hA0);
        rdc("count_h", IDX_COUNT_H, 8'h00);
        wr(IDX_CONFIG, 8'hFF);
        rdc("config", IDX_CONFIG, 8'hBB);
        wr(IDX_CONFIG, 8'h01);
        wr(IDX_RELOAD_H, 8'h00);
        wr(IDX_RELOAD_L, 8'h03);
        wr(IDX_RUN_CTL, 8'h10);
        chk("no_mask", act_o, 1'b0);
        chk("no_mask_oth", ost_o | osp_o, 3'h0);
        wr(IDX_RUN_CTL, 8'h11);
        chk("start", act_o, 1'b1);
        rdc("run_ctl", IDX_RUN_CTL, 8'hB0);
        wr(IDX_RELOAD_L, 8'hFF);
        acc(1'b0, IDX_COUNT_L, 8'h00);
        chk("live", rd <= 8'h03, 1'b1);
        n = 0;
        while (act_o === 1'b1 && n < 3000) begin
            @(negedge ref_clk_i);
            n++;
        end
        chk("slow_rate", (n > 2 * (CLK_HZ / SLOW_HZ)) && (n <= 4 * (CLK_HZ / SLOW_HZ)), 1'b1);
        repeat (2) @(negedge ref_clk_i);
        chk("halt_zero", act_o, 1'b0);
        chk("flag", flag_o, 1'b1);
        chk("uf_count", uf_n, 1);
        rdc("count_l", IDX_COUNT_L, 8'h00);
        wr(IDX_CONFIG, 8'h02);
        wr(IDX_RUN_CTL, 8'h11);
        rdc("reload", IDX_COUNT_L, 8'hFF);
        wr(IDX_RUN_CTL, 8'h01);
        chk("stop", act_o, 1'b0);
        e1 = '0;
        e1.tx_done = 1'b1;
        ev(e1, 1);
        chk("mode_sw", act_o, 1'b0);
        wr(IDX_CONFIG, 8'h12);
        ev(e1, 1);
        chk("mode_tx", act_o, 1'b1);
        wr(IDX_CONFIG, 8'h92);
        e2 = '0;
        e2.rx_first_bits = 1'b1;
        ev(e2, 1);
        chk("halt_rx", act_o, 1'b0);
        wr(IDX_CONFIG, 8'hB2);
        wr(IDX_RUN_CTL, 8'h11);
        ev(e2, 1);
        chk("trim_no_halt", act_o, 1'b1);
        wr(IDX_RELOAD_L, 8'h01);
        for (int i = 0; i < 2; i++) begin
            e1 = '0;
            e2 = '0;
            e1.timer_two_underflow = (i == 0);
            e1.timer_one_underflow = (i == 1);
            e2.timer_two_underflow = (i == 1);
            e2.timer_one_underflow = (i == 0);
            wr(IDX_CONFIG, 8'h0A + 8'(i));
            wr(IDX_RUN_CTL, 8'h11);
            base = uf_n;
            ev(e2, 4);
            chk("other_src", uf_n - base, 0);
            ev(e1, 4);
            chk("cascade_uf", uf_n - base, 2);
            chk("auto_run", act_o, 1'b1);
        end
        wr(IDX_RUN_CTL, 8'hEE);
        chk("oth_start", ost_o, 3'h7);
        chk("oth_start_stop", osp_o, 3'h0);
        wr(IDX_RUN_CTL, 8'h0E);
        chk("oth_stop", osp_o, 3'h7);
        chk("oth_stop_start", ost_o, 3'h0);
        wr(IDX_RUN_CTL, 8'h01);
        wr(IDX_FLAGS, 8'h01);
        chk("flag_clr", flag_o, 1'b0);
        wr(IDX_CONFIG, 8'h20);
        base = uf_n;
        @(posedge ref_clk_i);
        osc_i <= 1'b1;
        repeat (6) @(negedge ref_clk_i);
        chk("trim_start", act_o, 1'b1);
        repeat (20) @(negedge ref_clk_i);
        chk("trim_hold", act_o, 1'b1);
        chk("trim_no_uf", uf_n - base, 0);
        chk("trim_flag", flag_o, 1'b0);
        rdc("trim_zero", IDX_COUNT_L, 8'h00);
        @(posedge ref_clk_i);
        osc_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        osc_i <= 1'b1;
        repeat (6) @(negedge ref_clk_i);
        chk("trim_stop", act_o, 1'b0);
        print_verdict();
    end
endmodule
